//--- host_bus_data_and_irq_pins.sv
// host parallel bus pins: data bus, strobes and interrupt output
`timescale 1ns/10ps
module host_bus_data_and_irq_pins (
    input  wire logic                           clock,
    input  wire logic                           srst,
    input  wire logic                           clock_en,
    // pins from the host, asynchronous to clock
    input  wire host_bus_pkg::host_pins_s       pins,
    // controller side, same clock
    input  wire logic [host_bus_pkg::DATA_W-1:0] read_data,
    input  wire logic                           irq_request,
    input  wire logic                           irq_drive_both,
    // access toward the register file
    output      logic                           read_pulse,
    output      logic                           write_pulse,
    output      logic [host_bus_pkg::SEL_W-1:0] access_addr,
    output      logic [host_bus_pkg::DATA_W-1:0] write_data,
    // data bus pin drive
    output      logic [host_bus_pkg::DATA_W-1:0] data_out,
    output      logic                           data_oe,
    // interrupt pin drive
    output      logic                           irq_out,
    output      logic                           irq_oe
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    host_bus_pkg::host_pins_s  meta;
    host_bus_pkg::host_pins_s  s;

    // two stages; only the second stage is looked at by any logic
    always_ff @(posedge clock) begin
        if (srst) begin
            meta <= host_bus_pkg::PINS_RST;
            s    <= host_bus_pkg::PINS_RST;
        end else if (clock_en) begin
            meta <= pins;
            s    <= meta;
        end
    end

    // ------------------------------------------------------------
    // bit order and strobe decode
    // ------------------------------------------------------------
    logic [host_bus_pkg::DATA_W-1:0] bus_byte;
    wire  logic strobe_mode = (s.bus_sel == host_bus_pkg::MODE_STROBE);
    wire  logic selected    = (s.chip_select_n == host_bus_pkg::PIN_LOW);
    wire  logic rd16 = selected && !s.read_strobe_n;
    wire  logic wr16 = selected && !s.write_strobe_n;
    wire  logic rd68 = selected && s.write_strobe_n;
    wire  logic wr68 = selected && !s.write_strobe_n;
    wire  logic rd_act = strobe_mode ? rd16 : rd68;
    wire  logic wr_act = strobe_mode ? wr16 : wr68;

    // pin i lands on byte bit i, so bit zero is the first on the line
    genvar gi;
    generate
        for (gi = 0; gi < host_bus_pkg::DATA_W; gi++) begin : g_bit
            assign bus_byte[gi] = s.data[gi];
        end
    endgenerate

    // ------------------------------------------------------------
    // access sequencer
    // ------------------------------------------------------------
    host_bus_pkg::access_state_e state;
    host_bus_pkg::access_state_e next_state;

    // a write is posted at the trailing edge so the data has settled
    always_comb begin
        next_state = state;
        case (state)
            host_bus_pkg::IDLE: begin
                if (rd_act) begin
                    next_state = host_bus_pkg::READ;
                end else if (wr_act) begin
                    next_state = host_bus_pkg::WRITE;
                end
            end
            host_bus_pkg::READ: begin
                if (!rd_act) begin
                    next_state = host_bus_pkg::IDLE;
                end
            end
            host_bus_pkg::WRITE: begin
                if (!wr_act) begin
                    next_state = host_bus_pkg::IDLE;
                end
            end
            default: begin
                next_state = host_bus_pkg::IDLE;
            end
        endcase
    end

    wire logic start_rd  = (state == host_bus_pkg::IDLE) && rd_act;
    wire logic end_wr    = (state == host_bus_pkg::WRITE) && !wr_act;
    wire logic hold_wr   = (state == host_bus_pkg::WRITE) && wr_act;
    wire logic take_addr = (state == host_bus_pkg::IDLE) && (rd_act || wr_act);

    // state, pulses and the captured address and data
    always_ff @(posedge clock) begin
        if (srst) begin
            state       <= host_bus_pkg::IDLE;
            read_pulse  <= 1'h0;
            write_pulse <= 1'h0;
            access_addr <= host_bus_pkg::SEL_RST;
            write_data  <= host_bus_pkg::DATA_RST;
        end else if (clock_en) begin
            state       <= next_state;
            read_pulse  <= start_rd;
            write_pulse <= end_wr;
            if (take_addr) begin
                access_addr <= s.reg_sel;
            end
            if (hold_wr) begin
                write_data <= bus_byte;
            end
        end
    end

    // ------------------------------------------------------------
    // data bus drive
    // ------------------------------------------------------------
    // released as soon as the read ends; the synchroniser lag means the
    // host must allow about three clocks of turn-off after its strobe
    always_ff @(posedge clock) begin
        if (srst) begin
            data_out <= host_bus_pkg::DATA_RST;
            data_oe  <= 1'h0;
        end else if (clock_en) begin
            data_out <= read_data;
            data_oe  <= rd_act;
        end
    end

    // ------------------------------------------------------------
    // interrupt pin drive
    // ------------------------------------------------------------
    wire logic push_pull = strobe_mode &&
                           (irq_drive_both == host_bus_pkg::DRIVE_BOTH);
    wire logic next_irq_out = strobe_mode ? (push_pull ? irq_request
                                                       : host_bus_pkg::PIN_HIGH)
                                          : host_bus_pkg::PIN_LOW;
    wire logic next_irq_oe  = push_pull ? 1'h1 : irq_request;

    // active high in strobe mode, open drain low in read/write mode
    always_ff @(posedge clock) begin
        if (srst) begin
            irq_out <= host_bus_pkg::PIN_LOW;
            irq_oe  <= 1'h0;
        end else if (clock_en) begin
            irq_out <= next_irq_out;
            irq_oe  <= next_irq_oe;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    bus_drive_a: assert property (clock_en && rd_act |=> data_oe)
        else $error("data bus not driven during a read");
    bus_release_a: assert property (clock_en && !rd_act |=> !data_oe)
        else $error("data bus driven outside a read");
    irq_high_a: assert property (
        clock_en && strobe_mode && irq_request |=> irq_out && irq_oe)
        else $error("strobe mode interrupt not active high");
    irq_both_a: assert property (
        clock_en && push_pull
        |=> irq_oe && irq_out == $past(irq_request))
        else $error("push-pull interrupt not driven both ways");
    irq_source_a: assert property (
        clock_en && strobe_mode && !push_pull
        |=> irq_out && irq_oe == $past(irq_request))
        else $error("open-source interrupt drives idle level");
    irq_drain_a: assert property (
        clock_en && !strobe_mode
        |=> !irq_out && irq_oe == $past(irq_request))
        else $error("open-drain interrupt wrong");
    write_post_a: assert property (
        clock_en && end_wr
        |=> write_pulse ##1 (!write_pulse || !clock_en))
        else $error("write not posted once at strobe end");
    write_capture_a: assert property (
        clock_en && hold_wr |=> write_data == $past(bus_byte))
        else $error("write data not captured in bit order");
    mode_rw_read_a: assert property (
        clock_en && !strobe_mode && selected && s.write_strobe_n
        |=> data_oe)
        else $error("read/write mode read not decoded");
    read_once_a: assert property (
        clock_en && start_rd
        |=> read_pulse ##1 (!read_pulse || !clock_en))
        else $error("read pulse wrong");

    // the two bus styles must never borrow each other's read decode
    strobe_no_rw_a: assert property (
        clock_en && strobe_mode && s.read_strobe_n |=> !data_oe)
        else $error("strobe mode read without the read strobe");
    mode_rw_write_a: assert property (
        clock_en && !strobe_mode && !s.write_strobe_n |=> !data_oe)
        else $error("read/write mode write drove the bus");
    addr_take_a: assert property (
        clock_en && take_addr |=> access_addr == $past(s.reg_sel))
        else $error("register select not latched at access start");

    strobe_read_c: cover property (strobe_mode && start_rd ##[1:20] !data_oe);
    rw_write_c: cover property (!strobe_mode && hold_wr ##[1:20] write_pulse);
    irq_drain_c: cover property (!strobe_mode && irq_oe);
    irq_push_c: cover property (push_pull ##1 irq_out ##[1:20] !irq_out);
    freeze_c: cover property (!clock_en && irq_request ##1 !clock_en);

endmodule : host_bus_data_and_irq_pins

//--- host_bus_pkg.sv
// shared types and constants for the host bus pin block
package host_bus_pkg;

    // ------------------------------------------------------------
    // widths and field positions
    // ------------------------------------------------------------
    localparam int DATA_W     = 8;
    localparam int SEL_W      = 3;
    localparam int LSB_POS    = 0;   // bit shifted first on the line
    localparam int MSB_POS    = 7;   // bit shifted last on the line

    // ------------------------------------------------------------
    // reset values and pin levels
    // ------------------------------------------------------------
    localparam logic [7:0] DATA_RST  = 8'h00;
    localparam logic [2:0] SEL_RST   = 3'h0;
    localparam logic       PIN_HIGH  = 1'h1;
    localparam logic       PIN_LOW   = 1'h0;
    localparam logic       MODE_STROBE = 1'h1; // bus select high or open
    localparam logic       MODE_RW     = 1'h0; // bus select low
    localparam logic       DRIVE_BOTH  = 1'h1; // interrupt style bit set

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    // raw host pins as sampled
    typedef struct packed {
        logic             bus_sel;
        logic             chip_select_n;
        logic             read_strobe_n;
        logic             write_strobe_n; // read/write line in rw mode
        logic [SEL_W-1:0] reg_sel;
        logic [DATA_W-1:0] data;
    } host_pins_s;

    // access handed to the register side of the controller
    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [SEL_W-1:0]  addr;
        logic [DATA_W-1:0] data;
    } access_s;

    localparam host_pins_s PINS_RST = '{bus_sel: 1'h1,
                                        chip_select_n: 1'h1,
                                        read_strobe_n: 1'h1,
                                        write_strobe_n: 1'h1,
                                        reg_sel: 3'h0,
                                        data: 8'h00};

    typedef enum logic [2:0] {
        IDLE  = 3'h1,
        READ  = 3'h2,
        WRITE = 3'h4
    } access_state_e;

endpackage : host_bus_pkg

//--- host_cpu_model.sv
// host cpu model that drives the parallel bus pins
`timescale 1ns/10ps
module host_cpu_model (
    input  wire logic                        clock,
    input  wire logic                        data_oe,
    input  wire logic [7:0]                  data_out,
    output host_bus_pkg::host_pins_s         pins
);
    // ------------------------------------------------------------
    // pin driving
    // ------------------------------------------------------------
    initial pins = host_bus_pkg::PINS_RST;

    // idle: a released bus shows the inverse of the last value, no pull
    task automatic idle(input logic mode, input logic [7:0] last);
        pins <= '{mode, 1'h1, 1'h1, 1'h1, 3'h0, ~last};
    endtask : idle

    // one access, strobes held seven cycles; read data is taken at the end
    task automatic access(input logic mode, input logic rd,
                          input logic cs_n, input logic [2:0] sel,
                          input logic [7:0] wd, output logic [7:0] got);
        @(posedge clock);
        pins <= '{mode, cs_n, ~(rd & mode), rd, sel,
                  rd ? ~wd : wd};
        repeat (6) @(posedge clock);
        #1 got = data_oe ? data_out : pins.data;
        @(posedge clock);
        idle(mode, pins.data);
        repeat (5) @(posedge clock);
    endtask : access
endmodule : host_cpu_model

//--- host_bus_data_and_irq_pins_tb.sv
// testbench for the host bus pin block
`timescale 1ns/10ps
module host_bus_data_and_irq_pins_tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic                      clock = 1'h0;
    logic                      srst = 1'h1;
    logic                      clock_en = 1'h1;
    logic [7:0]                read_data = 8'h00;
    logic                      irq_request = 1'h0;
    logic                      irq_drive_both = 1'h0;
    host_bus_pkg::host_pins_s  pins;
    logic                      read_pulse, write_pulse, data_oe;
    logic                      irq_out, irq_oe;
    logic [2:0]                access_addr;
    logic [7:0]                write_data, data_out;
    int                        n_mismatch = 0, n_checks = 0;
    int                        n_rp = 0, n_wp = 0;

    always #4 clock = ~clock;
    // pulses are counted so a missing or doubled one shows
    always @(posedge clock) begin
        if (read_pulse === 1'h1) n_rp++;
        if (write_pulse === 1'h1) n_wp++;
    end

    host_bus_data_and_irq_pins dut (.clock(clock), .srst(srst),
        .clock_en(clock_en), .pins(pins), .read_data(read_data),
        .irq_request(irq_request), .irq_drive_both(irq_drive_both),
        .read_pulse(read_pulse), .write_pulse(write_pulse),
        .access_addr(access_addr), .write_data(write_data),
        .data_out(data_out), .data_oe(data_oe), .irq_out(irq_out),
        .irq_oe(irq_oe));
    host_cpu_model host (.clock(clock), .data_oe(data_oe),
        .data_out(data_out), .pins(pins));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'h1) begin
            n_mismatch++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : check

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results

    // host read must return the register value on the bus, then release
    task automatic read_test(input logic mode, input logic [2:0] sel,
                             input logic [7:0] val);
        logic [7:0] got;
        int         rp0;
        rp0 = n_rp;
        @(posedge clock);
        read_data <= val;
        host.access(mode, 1'h1, 1'h0, sel, val, got);
        check(got === val, "read data");
        check(n_rp - rp0 == 1, "read pulse count");
        check(access_addr === sel, "read address");
        check(data_oe === 1'h0, "bus not released");
    endtask : read_test

    // write; with chip select high nothing may be taken
    task automatic write_test(input logic mode, input logic cs_n,
                              input logic [2:0] sel, input logic [7:0] val);
        logic [7:0] got;
        int         wp0;
        wp0 = n_wp;
        host.access(mode, 1'h0, cs_n, sel, val, got);
        check(n_wp - wp0 == (cs_n ? 0 : 1), "write pulses");
        check(data_oe === 1'h0, "bus driven on write");
        if (!cs_n) begin
            check(write_data === val, "write data");
            check(access_addr === sel, "write address");
        end
    endtask : write_test

    // interrupt pin level and drive in each mode and style
    task automatic irq_test(input logic mode, input logic both,
                            input logic req);
        logic exp_oe, exp_out;
        @(posedge clock);
        host.idle(mode, 8'h00);
        irq_request <= req;
        irq_drive_both <= both;
        repeat (5) @(posedge clock);
        #1;
        exp_oe = mode ? (both | req) : req;
        exp_out = mode ? (both ? req : 1'h1) : 1'h0;
        check(irq_oe === exp_oe, "irq drive enable");
        if (exp_oe) check(irq_out === exp_out, "irq level");
    endtask : irq_test

    // a mid-run reset must drop both pin drives, then recover cleanly
    task automatic reset_test;
        @(posedge clock);
        host.idle(1'h1, 8'h00);
        irq_request <= 1'h1;
        irq_drive_both <= 1'h1;
        repeat (5) @(posedge clock);
        srst <= 1'h1;
        repeat (2) @(posedge clock);
        #1;
        check(irq_oe === 1'h0 && irq_out === 1'h0, "irq in reset");
        check(data_oe === 1'h0, "bus driven in reset");
        @(posedge clock);
        srst <= 1'h0;
        repeat (5) @(posedge clock);
        #1;
        check(irq_oe === 1'h1 && irq_out === 1'h1, "irq after reset");
        @(posedge clock);
        irq_request <= 1'h0;
        irq_drive_both <= 1'h0;
    endtask : reset_test

    // with clock enable low nothing may move, even a changed request
    task automatic freeze_test;
        @(posedge clock);
        host.idle(1'h1, 8'h00);
        irq_request <= 1'h0;
        irq_drive_both <= 1'h0;
        repeat (5) @(posedge clock);
        clock_en <= 1'h0;
        irq_request <= 1'h1;
        repeat (5) @(posedge clock);
        #1;
        check(irq_oe === 1'h0, "irq moved while frozen");
        @(posedge clock);
        clock_en <= 1'h1;
        repeat (2) @(posedge clock);
        #1;
        check(irq_oe === 1'h1 && irq_out === 1'h1, "irq after freeze");
        @(posedge clock);
        irq_request <= 1'h0;
    endtask : freeze_test

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clock);
        srst <= 1'h0;
        repeat (3) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            irq_test(i[2], i[1], i[0]);
        end
        reset_test();
        freeze_test();
        read_test(1'h1, 3'h7, 8'hA5);
        read_test(1'h0, 3'h1, 8'h5A);
        write_test(1'h1, 1'h0, 3'h5, 8'h01);
        check(write_data[host_bus_pkg::LSB_POS] === 1'h1, "lsb");
        write_test(1'h0, 1'h0, 3'h2, 8'h80);
        check(write_data[host_bus_pkg::MSB_POS] === 1'h1, "msb");
        write_test(1'h1, 1'h1, 3'h3, 8'h3C);
        results();
    end

    // the run needs well under 300 cycles
    initial begin
        #20000;
        n_mismatch++;
        $display("BAD %0t watchdog expired", $time);
        results();
    end
endmodule : host_bus_data_and_irq_pins_tb
